//--- hdl/cxi_defines.vh
// Purpose: constants for the extended identifier field block
// Assumes: 32-bit AXI4-Lite register bus, byte-wide identifier registers
// Notes: offsets are byte addresses of one aligned word each
`ifndef CXI_DEFINES_VH
`define CXI_DEFINES_VH
`define CXI_OFS_TX_UPPER 6'h00
`define CXI_OFS_TX_UPPER_MID 6'h04
`define CXI_OFS_TX_LOWER_MID 6'h08
`define CXI_OFS_TX_LOWER 6'h0c
`define CXI_OFS_RX_UPPER 6'h10
`define CXI_OFS_RX_UPPER_MID 6'h14
`define CXI_OFS_RX_LOWER_MID 6'h18
`define CXI_OFS_RX_LOWER 6'h1c
`define CXI_OFS_CTRL 6'h20
`define CXI_OFS_STATUS 6'h24
`define CXI_OFS_BITRATE 6'h28
`define CXI_BIT_SRR 4
`define CXI_BIT_IDE 3
`define CXI_BIT_RTR 0
`define CXI_CTRL_GO 0
`define CXI_ST_BUSY 0
`define CXI_ST_RX_FULL 1
`define CXI_ST_LOST 2
`define CXI_ST_DONE 3
`define CXI_BITRATE_RST 16'h0032
`define CXI_RESP_OKAY 2'b00
`define CXI_RESP_SLVERR 2'b10
`endif

//--- hdl/cxi_bit_tick.v
// Purpose: bit-time enable generator
// Assumes: single clock, divisor from a register
// Notes: one-cycle pulse every div cycles; div of zero acts as one
`timescale 1ns/1ps
module cxi_bit_tick
#(
    parameter WIDTH = 16
)
(
    input wire aclk,
    input wire aresetn,
    input wire run,
    input wire [WIDTH-1:0] div,
    output reg tick_ff
);
    reg [WIDTH-1:0] cnt_ff;
    // restart on idle so the first bit gets a full period
    always @(posedge aclk)
    begin
        if (!aresetn || !run)
        begin
            cnt_ff <= {WIDTH{1'b0}};
            tick_ff <= 1'b0;
        end
        else if (cnt_ff + 1'b1 >= div)
        begin
            cnt_ff <= {WIDTH{1'b0}};
            tick_ff <= 1'b1;
        end
        else
        begin
            cnt_ff <= cnt_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end
endmodule

//--- hdl/cxi_shifter.v
// Purpose: arbitration-field shifter, msb first
// Assumes: bit enable from cxi_bit_tick, open-drain style line
// Notes: shifts nbits field bits, at most 32; yields on a dominant read-back of a recessive bit
`timescale 1ns/1ps
module cxi_shifter
(
    input wire aclk,
    input wire aresetn,
    input wire start,
    input wire tick,
    input wire [31:0] field,
    input wire [5:0] nbits,
    input wire line_in,
    output reg line_out_ff,
    output reg busy_ff,
    output reg lost_ff,
    output reg done_ff,
    output reg [31:0] rx_ff
);
    reg [31:0] sh_ff;
    reg [5:0] left_ff;
    // recessive is 1; a 0 seen while sending 1 means a lower identifier won
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sh_ff <= 32'h0000_0000;
            left_ff <= 6'h00;
            line_out_ff <= 1'b1;
            busy_ff <= 1'b0;
            lost_ff <= 1'b0;
            done_ff <= 1'b0;
            rx_ff <= 32'h0000_0000;
        end
        else
        begin
            done_ff <= 1'b0;
            if (start && !busy_ff)
            begin
                sh_ff <= field;
                left_ff <= nbits;
                busy_ff <= 1'b1;
                lost_ff <= 1'b0;
                line_out_ff <= field[31];
            end
            else if (busy_ff && tick)
            begin
                rx_ff <= {rx_ff[30:0], line_in};
                if (line_out_ff && !line_in && !lost_ff)
                begin
                    lost_ff <= 1'b1;
                end
                if (left_ff == 6'h01)
                begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                    line_out_ff <= 1'b1;
                end
                else
                begin
                    left_ff <= left_ff - 6'h01;
                    sh_ff <= {sh_ff[30:0], 1'b1};
                    // after losing, keep sending recessive and just listen
                    line_out_ff <= (lost_ff || (line_out_ff && !line_in)) ? 1'b1 : sh_ff[30];
                end
            end
        end
    end
endmodule

//--- hdl/cxi_top.v
// Purpose: extended identifier fields of one transmit and one receive buffer
// Assumes: AXI4-Lite slave, 50 MHz aclk, synchronous active-low reset
// Notes: the arbitration field is shifted msb first on an open-drain line
`timescale 1ns/1ps
`include "cxi_defines.vh"
// How it works
// - extended identifier is 29 bits across bytes
// - identifier sent msb first, bit 28 first
// - lowest identifier wins arbitration
// - second byte: id20-18, srr, ide, id17-15
// - third byte holds bits 14 to 7
// - fourth byte: id6-0 then rtr
// - receive srr stored as sampled
// - ide picks standard or extended format
// - receive ide follows received format; stored as zero when the block sends a standard frame
// - rtr picks data or remote frame
// - receive rtr loaded from received frame
// - srr and ide both one when extended; srr is sent as written and the received srr is stored as sampled
// - four bytes form one 32-bit field
module cxi_top
(
    input wire aclk,
    input wire aresetn,
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire can_rx,
    output reg can_tx_out_ff,
    output reg can_tx_oe_n_ff
);
    // transmit identifier bytes, software owned
    reg [7:0] ident_byte_upper_ff;
    reg [7:0] ident_byte_upper_mid_ff;
    reg [7:0] ident_byte_lower_mid_ff;
    reg [7:0] ident_byte_lower_ff;
    // receive identifier bytes, hardware owned
    reg [7:0] rx_upper_ff;
    reg [7:0] rx_upper_mid_ff;
    reg [7:0] rx_lower_mid_ff;
    reg [7:0] rx_lower_ff;
    reg [15:0] bitrate_ff;
    reg go_ff;
    reg rx_full_ff;
    reg lost_flag_ff;
    reg done_flag_ff;
    reg aw_hold_ff;
    reg w_hold_ff;
    reg [5:0] aw_addr_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;
    wire tick;
    wire sh_line;
    wire sh_busy;
    wire sh_lost;
    wire sh_done;
    wire [31:0] sh_rx;
    wire [31:0] tx_field;
    wire [31:0] tx_std_field;
    wire tx_ide;
    wire [5:0] tx_bits;
    wire do_write;
    wire [31:0] rd_word;
    wire clr_rx;
    wire clr_lost;
    wire clr_done;

    // unpack a received shift word into the four byte layout
    function [31:0] pack_rx;
        input [31:0] w;
        input ide;
        begin
            if (ide)
            begin
                // extended: id28..18, srr, ide, id17..0, rtr in stream order
                pack_rx = {w[31:21], w[20], 1'b1, w[18:1], w[0]};
            end
            else
            begin
                // standard: id10..0, rtr, ide placed in the second byte
                pack_rx = {w[31:21], w[20], 1'b0, 3'b000, 16'h0000};
            end
        end
    endfunction

    // byte-lane merge for a register write
    function [7:0] lane0;
        input [7:0] old;
        input [31:0] d;
        input [3:0] s;
        begin
            lane0 = s[0] ? d[7:0] : old;
        end
    endfunction

    // the 32-bit field: id28..21 | id20..18 srr ide id17..15 | id14..7 | id6..0 rtr
    assign tx_field = {ident_byte_upper_ff, ident_byte_upper_mid_ff,
        ident_byte_lower_mid_ff, ident_byte_lower_ff};
    assign tx_ide = ident_byte_upper_mid_ff[`CXI_BIT_IDE];
    // standard frame sends id10..0 then rtr, taken from the standard positions
    assign tx_std_field = {ident_byte_upper_ff, ident_byte_upper_mid_ff[7:4], 20'h0_0000};
    // extended: 11 id, srr, ide, 18 id, rtr = 32 bits; standard: 11 id, rtr = 12
    assign tx_bits = tx_ide ? 6'd32 : 6'd12;

    cxi_bit_tick #(.WIDTH(16)) u_tick
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(sh_busy),
        .div(bitrate_ff),
        .tick_ff(tick)
    );

    cxi_shifter u_shift
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(go_ff),
        .tick(tick),
        .field(tx_ide ? tx_field : tx_std_field),
        .nbits(tx_bits),
        .line_in(can_rx),
        .line_out_ff(sh_line),
        .busy_ff(sh_busy),
        .lost_ff(sh_lost),
        .done_ff(sh_done),
        .rx_ff(sh_rx)
    );

    // write channel: address and data taken in either order, held until both
    assign do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            aw_addr_ff <= 6'h00;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CXI_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_hold_ff && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_ff && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_ff)
                    `CXI_OFS_TX_UPPER, `CXI_OFS_TX_UPPER_MID, `CXI_OFS_TX_LOWER_MID,
                    `CXI_OFS_TX_LOWER, `CXI_OFS_CTRL, `CXI_OFS_STATUS, `CXI_OFS_BITRATE,
                    `CXI_OFS_RX_UPPER, `CXI_OFS_RX_UPPER_MID, `CXI_OFS_RX_LOWER_MID,
                    `CXI_OFS_RX_LOWER:
                        s_axi_bresp <= `CXI_RESP_OKAY;
                    default:
                        s_axi_bresp <= `CXI_RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // transmit bytes and control; writes are refused while a frame is shifting
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ident_byte_upper_ff <= 8'h00;
            ident_byte_upper_mid_ff <= 8'h18; // srr and ide set: valid extended field
            ident_byte_lower_mid_ff <= 8'h00;
            ident_byte_lower_ff <= 8'h00;
            bitrate_ff <= `CXI_BITRATE_RST;
            go_ff <= 1'b0;
        end
        else
        begin
            go_ff <= 1'b0;
            if (do_write && !sh_busy)
            begin
                case (aw_addr_ff)
                    `CXI_OFS_TX_UPPER:
                        ident_byte_upper_ff <= lane0(ident_byte_upper_ff, w_data_ff,
                            w_strb_ff);
                    `CXI_OFS_TX_UPPER_MID:
                        ident_byte_upper_mid_ff <= lane0(ident_byte_upper_mid_ff, w_data_ff,
                            w_strb_ff);
                    `CXI_OFS_TX_LOWER_MID:
                        ident_byte_lower_mid_ff <= lane0(ident_byte_lower_mid_ff, w_data_ff,
                            w_strb_ff);
                    `CXI_OFS_TX_LOWER:
                        ident_byte_lower_ff <= lane0(ident_byte_lower_ff, w_data_ff,
                            w_strb_ff);
                    `CXI_OFS_BITRATE:
                    begin
                        if (w_strb_ff[0])
                            bitrate_ff[7:0] <= w_data_ff[7:0];
                        if (w_strb_ff[1])
                            bitrate_ff[15:8] <= w_data_ff[15:8];
                    end
                    `CXI_OFS_CTRL:
                        go_ff <= w_strb_ff[0] && w_data_ff[`CXI_CTRL_GO];
                    default:
                        go_ff <= 1'b0;
                endcase
            end
        end
    end

    // status write-one-to-clear strobes
    assign clr_rx = do_write && aw_addr_ff == `CXI_OFS_STATUS && w_strb_ff[0]
        && w_data_ff[`CXI_ST_RX_FULL];
    assign clr_lost = do_write && aw_addr_ff == `CXI_OFS_STATUS && w_strb_ff[0]
        && w_data_ff[`CXI_ST_LOST];
    assign clr_done = do_write && aw_addr_ff == `CXI_OFS_STATUS && w_strb_ff[0]
        && w_data_ff[`CXI_ST_DONE];

    // receive capture: a lost arbitration means another node's frame was read in;
    // a set beats a same-cycle clear for lost and done; a frame ending while rx full is set is dropped, even when a same-cycle clear empties rx full
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_upper_ff <= 8'h00;
            rx_upper_mid_ff <= 8'h00;
            rx_lower_mid_ff <= 8'h00;
            rx_lower_ff <= 8'h00;
            rx_full_ff <= 1'b0;
            lost_flag_ff <= 1'b0;
            done_flag_ff <= 1'b0;
        end
        else
        begin
            if (sh_done && sh_lost && !rx_full_ff)
            begin
                // ide is the bit after srr; a 12-bit frame sits low and is moved up first
                {rx_upper_ff, rx_upper_mid_ff, rx_lower_mid_ff, rx_lower_ff} <=
                    pack_rx(tx_ide ? sh_rx : {sh_rx[11:0], 20'h0_0000},
                    tx_ide && sh_rx[19]);
                rx_full_ff <= 1'b1;
            end
            else if (clr_rx)
                rx_full_ff <= 1'b0;
            if (sh_done && sh_lost)
                lost_flag_ff <= 1'b1;
            else if (clr_lost)
                lost_flag_ff <= 1'b0;
            if (sh_done && !sh_lost)
                done_flag_ff <= 1'b1;
            else if (clr_done)
                done_flag_ff <= 1'b0;
        end
    end

    // pin drive: open drain, enable low only while pulling dominant
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            can_tx_out_ff <= 1'b0;
            can_tx_oe_n_ff <= 1'b1;
        end
        else
        begin
            can_tx_out_ff <= 1'b0;
            can_tx_oe_n_ff <= sh_line;
        end
    end

    // read mux; byte registers sit in the low lane, upper bits read zero
    assign rd_word =
        (s_axi_araddr == `CXI_OFS_TX_UPPER) ? {24'h00_0000, ident_byte_upper_ff} :
        (s_axi_araddr == `CXI_OFS_TX_UPPER_MID) ? {24'h00_0000, ident_byte_upper_mid_ff} :
        (s_axi_araddr == `CXI_OFS_TX_LOWER_MID) ? {24'h00_0000, ident_byte_lower_mid_ff} :
        (s_axi_araddr == `CXI_OFS_TX_LOWER) ? {24'h00_0000, ident_byte_lower_ff} :
        (s_axi_araddr == `CXI_OFS_RX_UPPER) ? {24'h00_0000, rx_upper_ff} :
        (s_axi_araddr == `CXI_OFS_RX_UPPER_MID) ? {24'h00_0000, rx_upper_mid_ff} :
        (s_axi_araddr == `CXI_OFS_RX_LOWER_MID) ? {24'h00_0000, rx_lower_mid_ff} :
        (s_axi_araddr == `CXI_OFS_RX_LOWER) ? {24'h00_0000, rx_lower_ff} :
        // busy covers the cycle in which the end-of-frame flags are posted
        (s_axi_araddr == `CXI_OFS_STATUS) ? {28'h000_0000, done_flag_ff, lost_flag_ff,
            rx_full_ff, sh_busy || sh_done} :
        (s_axi_araddr == `CXI_OFS_BITRATE) ? {16'h0000, bitrate_ff} :
        32'h0000_0000;

    // read channel: one cycle accept, data next cycle, held until taken
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CXI_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                case (s_axi_araddr)
                    `CXI_OFS_TX_UPPER, `CXI_OFS_TX_UPPER_MID, `CXI_OFS_TX_LOWER_MID,
                    `CXI_OFS_TX_LOWER, `CXI_OFS_RX_UPPER, `CXI_OFS_RX_UPPER_MID,
                    `CXI_OFS_RX_LOWER_MID, `CXI_OFS_RX_LOWER, `CXI_OFS_CTRL,
                    `CXI_OFS_STATUS, `CXI_OFS_BITRATE:
                        s_axi_rresp <= `CXI_RESP_OKAY;
                    default:
                        s_axi_rresp <= `CXI_RESP_SLVERR;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

//--- verification/cxi_top_sva.sv
// Purpose: port-level checker for the identifier field block
// Assumes: one clock domain, synchronous active-low reset
// Notes: sees only top-level ports; bound at the foot of this file
`timescale 1ns/1ps
module cxi_top_sva
(
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire can_tx_out_ff,
    input wire can_tx_oe_n_ff
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // a write is accepted when address and data are taken together
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence b_answer;
        s_axi_bvalid;
    endsequence

    chk_write_answer: assert property (aw_w_taken |-> ##[1:3] b_answer)
        else $error("write response missing");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("address ready longer than one cycle");
    chk_arready_cause: assert property ($rose(s_axi_arready) |-> $past(s_axi_arvalid))
        else $error("read address ready without request");
    chk_line_open_drain: assert property (!can_tx_out_ff)
        else $error("line driven recessive actively");
    chk_byte_lanes: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    chk_reset_quiet: assert property ($rose(aresetn) |->
        can_tx_oe_n_ff && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active after reset");
endmodule
bind cxi_top cxi_top_sva u_sva (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .can_tx_out_ff(can_tx_out_ff), .can_tx_oe_n_ff(can_tx_oe_n_ff));

//--- verification/cxi_bus_node.sv
// Purpose: another node on the bus contending with the block
// Assumes: same bit time as the block, started by the bench
// Notes: bit edges lag the block by a few cycles; sampling mid-bit hides that
`timescale 1ns/1ps
module cxi_bus_node
#(
    parameter DIV = 20
)
(
    input wire aclk,
    input wire aresetn,
    input wire start,
    input wire [5:0] nbits,
    input wire [31:0] field,
    input wire bus,
    output wire node_bit,
    output reg [31:0] heard_ff,
    output reg busy_ff
);
    reg [5:0] idx_ff;
    reg [7:0] cnt_ff;
    reg lost_ff;

    // msb first; released (recessive) once idle or beaten
    assign node_bit = (busy_ff && !lost_ff) ? field[idx_ff - 6'd1] : 1'b1;

    // bit timer, mid-bit sampling of the wire, back-off on loss
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            busy_ff <= 1'b0;
            idx_ff <= 6'd0;
            cnt_ff <= 8'd0;
            lost_ff <= 1'b0;
            heard_ff <= 32'h0000_0000;
        end
        else if (start)
        begin
            busy_ff <= 1'b1;
            idx_ff <= nbits;
            cnt_ff <= 8'd0;
            lost_ff <= 1'b0;
            heard_ff <= 32'h0000_0000;
        end
        else if (busy_ff)
        begin
            cnt_ff <= (cnt_ff == DIV - 1) ? 8'd0 : cnt_ff + 8'd1;
            if (cnt_ff == DIV / 2)
            begin
                heard_ff <= {heard_ff[30:0], bus};
                if (node_bit && !bus)
                    lost_ff <= 1'b1;
            end
            if (cnt_ff == DIV - 1)
            begin
                idx_ff <= idx_ff - 6'd1;
                if (idx_ff == 6'd1)
                    busy_ff <= 1'b0;
            end
        end
    end
endmodule

//--- verification/cxi_top_tb_top.sv
// Purpose: register and arbitration tests of the identifier field block
// Assumes: 50 MHz clock, bit time of 20 cycles programmed by the bench
// Notes: table rows contend against a second node on a wired-and line
`timescale 1ns/1ps
`include "cxi_defines.vh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED at %0t: got 0x%0h exp 0x%0h", $time, (got), (exp)); end end
module cxi_top_tb_top;
    logic aclk = 0, aresetn = 0;
    logic [5:0] awaddr = 0, araddr = 0, node_n = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, node_start = 0;
    logic [31:0] wdata = 0, node_field = 0, d, rdata, heard;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, tx_out, tx_oe_n, node_bit, node_busy;
    logic [31:0] t_dut [4], t_node [4], t_st [4], t_heard [4];
    logic [5:0] t_n [4];
    int failures = 0, n_tests = 0;
    // wired-and bus with pull-up: released pins read recessive
    wire can_bus = (tx_oe_n ? 1'b1 : tx_out) & node_bit;

    always #10 aclk = ~aclk;

    cxi_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .can_rx(can_bus), .can_tx_out_ff(tx_out),
        .can_tx_oe_n_ff(tx_oe_n));
    cxi_bus_node #(.DIV(20)) u_node (.aclk(aclk), .aresetn(aresetn), .start(node_start),
        .nbits(node_n), .field(node_field), .bus(can_bus), .node_bit(node_bit),
        .heard_ff(heard), .busy_ff(node_busy));

    // extended field in bus order: id28..18, srr, ide, id17..0, rtr
    function automatic logic [31:0] ext_f(logic [28:0] id, logic srr, logic ide, logic rtr);
        return {id[28:18], srr, ide, id[17:0], rtr};
    endfunction

    task automatic axi_wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        awaddr <= a; wdata <= v; wstrb <= 4'hf;
        awvalid <= 1; wvalid <= 1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid && bready) break;
            // late ready makes the slave hold its response for a cycle
            if (bvalid) bready <= 1;
        end
        rs = bresp;
        bready <= 0;
        if (n == 100) failures++;
    endtask

    task automatic axi_rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        araddr <= a; arvalid <= 1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid && rready) break;
            // late ready makes the slave hold its read data for a cycle
            if (rvalid) rready <= 1;
        end
        v = rdata;
        rs = rresp;
        rready <= 0;
        if (n == 100) failures++;
    endtask

    // four identifier bytes, one per word, upper byte first
    task automatic check_bytes(input logic [5:0] base, input logic [31:0] f);
        for (int j = 0; j < 4; j++)
        begin
            axi_rd(base + 6'(4 * j), d, r);
            `CHK(d, {24'h00_0000, f[31 - 8 * j -: 8]})
        end
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog well beyond three frames of 32 bits, one of 12 bits, and the register traffic
    initial
    begin
        repeat (20000) @(posedge aclk);
        failures++;
        final_report();
    end

    initial
    begin
        // free line, plain loss at srr, our lower id wins, standard 12-bit frame
        t_dut[0] = ext_f(29'h123_4567, 1, 1, 1);
        t_node[0] = 32'hffff_ffff; t_n[0] = 32; t_st[0] = 32'h0000_0008; t_heard[0] = t_dut[0];
        t_dut[1] = t_dut[0]; t_node[1] = ext_f(29'h123_4567, 0, 1, 0);
        t_n[1] = 32; t_st[1] = 32'h0000_0006; t_heard[1] = t_node[1];
        t_dut[2] = ext_f(29'h000_0100, 1, 1, 0); t_node[2] = ext_f(29'h000_0200, 1, 1, 0);
        t_n[2] = 32; t_st[2] = 32'h0000_0008; t_heard[2] = t_dut[2];
        t_dut[3] = 32'ha570_0000; t_node[3] = 32'hffff_ffff;
        t_n[3] = 12; t_st[3] = 32'h0000_0008; t_heard[3] = 32'h0000_0a57;
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        check_bytes(`CXI_OFS_TX_UPPER, 32'h0018_0000);
        check_bytes(`CXI_OFS_RX_UPPER, 32'h0000_0000);
        axi_rd(`CXI_OFS_BITRATE, d, r);
        `CHK(d, 32'h0000_0032)
        axi_rd(6'h2c, d, r);
        `CHK(r, `CXI_RESP_SLVERR)
        axi_wr(6'h2c, 32'h0000_00ff, r);
        `CHK(r, `CXI_RESP_SLVERR)
        // receive bytes are not writable by software
        axi_wr(`CXI_OFS_RX_UPPER, 32'h0000_00aa, r);
        axi_rd(`CXI_OFS_RX_UPPER, d, r);
        `CHK(d, 32'h0000_0000)
        axi_wr(`CXI_OFS_BITRATE, 32'h0000_0014, r);
        for (int k = 0; k < 4; k++)
        begin
            for (int j = 0; j < 4; j++)
                axi_wr(`CXI_OFS_TX_UPPER + 6'(4 * j),
                    {24'h00_0000, t_dut[k][31 - 8 * j -: 8]}, r);
            check_bytes(`CXI_OFS_TX_UPPER, t_dut[k]);
            node_field <= t_node[k];
            node_n <= t_n[k];
            axi_wr(`CXI_OFS_CTRL, 32'h0000_0001, r);
            @(posedge aclk) node_start <= 1;
            @(posedge aclk) node_start <= 0;
            for (int n = 0; n < 400; n++)
            begin
                axi_rd(`CXI_OFS_STATUS, d, r);
                if (d[0] === 1'b0) break;
            end
            `CHK(heard, t_heard[k])
            `CHK(d, t_st[k])
            if (k == 1)
                check_bytes(`CXI_OFS_RX_UPPER, t_node[1]);
            axi_wr(`CXI_OFS_STATUS, 32'h0000_000e, r);
            axi_rd(`CXI_OFS_STATUS, d, r);
            `CHK(d, 32'h0000_0000)
        end
        final_report();
    end
endmodule
